// >>> hw/regbank_pkg.sv
// constants for the regulator mode register bank
// assumes a 24-bit register port with 6-bit register offsets
package regbank_pkg;

  // ==========================================================
  // geometry and offsets
  localparam int         REG_W        = 24;
  localparam int         NUM_REGS     = 6;
  localparam int         ADDR_W       = 6;
  localparam int         SEL_W        = 2;
  localparam int         NUM_LDO      = 11;
  localparam int         NUM_GPO      = 4;
  typedef logic [REG_W-1:0] word_t;

  localparam logic [5:0] OFF_BUCK_MODE  = 6'h1d;
  localparam logic [5:0] OFF_VSET_A     = 6'h1e;
  localparam logic [5:0] OFF_VSET_B     = 6'h1f;
  localparam logic [5:0] OFF_MODE_A     = 6'h20;
  localparam logic [5:0] OFF_MODE_B     = 6'h21;
  localparam logic [5:0] OFF_MISC       = 6'h22;
  localparam logic [5:0] FIRST_OFFSET   = OFF_BUCK_MODE;

  // array index of each register, counted from the first offset
  localparam int IDX_BUCK   = 0;
  localparam int IDX_VSET_A = 1;
  localparam int IDX_VSET_B = 2;
  localparam int IDX_MODE_A = 3;
  localparam int IDX_MODE_B = 4;
  localparam int IDX_MISC   = 5;

  // ==========================================================
  // per register: writable bits, main-reset bits, off-reset bits
  localparam word_t WRITE_MASK [NUM_REGS] = '{
    24'h103f3f, 24'h075ff3, 24'h0001fc, 24'h1ffe3f, 24'h1ff3ef, 24'h003fc1};
  localparam word_t MAIN_MASK [NUM_REGS] = '{
    24'h000f0f, 24'h074003, 24'h0001fc, 24'h1f6c37, 24'h1ff3ef, 24'h003fc1};
  localparam word_t OFF_MASK [NUM_REGS] = '{
    24'h003030, 24'h000000, 24'h000000, 24'h000000, 24'h000000, 24'h000000};
  localparam word_t RESET_VAL [NUM_REGS] = '{
    24'h000a0a, 24'h024000, 24'h0001d8, 24'h000000, 24'h000000, 24'h000000};
  // first power-up values of the bits that no reset touches
  localparam word_t POWERUP_VAL [NUM_REGS] = '{
    24'h100000, 24'h000000, 24'h000000, 24'h009208, 24'h000000, 24'h000000};

  // ==========================================================
  // field positions
  localparam int BUCK_MODE_W    = 4;
  localparam int BUCK3_MODE_LSB = 0;
  localparam int BUCK3_HOLD_BIT = 4;
  localparam int BUCK3_OFF_BIT  = 5;
  localparam int BUCK4_MODE_LSB = 8;
  localparam int BUCK4_HOLD_BIT = 12;
  localparam int BUCK4_OFF_BIT  = 13;
  localparam int BOOST_EN_BIT   = 20;
  localparam int SHORT_PROT_BIT = 0;
  localparam int GPO_EN_LSB     = 6;
  localparam logic [3:0] MODE_PWM = 4'ha;
  localparam logic [3:0] MODE_OFF = 4'h0;

  // enable / standby-control bit of each ldo, and whether it sits in mode b
  localparam int LDO_EN_BIT   [NUM_LDO] = '{0, 3, 9, 12, 15, 18, 0, 6, 12, 15, 18};
  localparam int LDO_STBY_BIT [NUM_LDO] = '{1, 4, 10, 13, 16, 19, 1, 7, 13, 16, 19};
  localparam bit LDO_IN_B     [NUM_LDO] = '{0, 0, 0, 0, 0, 0, 1, 1, 1, 1, 1};

  // {hit, index} of a register offset
  function automatic logic [3:0] decode(input logic [ADDR_W-1:0] addr);
    logic [ADDR_W-1:0] d;
    d = addr - FIRST_OFFSET;
    decode = {(addr >= FIRST_OFFSET) && (d < ADDR_W'(NUM_REGS)), d[2:0]};
  endfunction

  // {buck4 on, buck3 on} chosen by the power-up mode select
  function automatic logic [1:0] select_bucks(input logic [SEL_W-1:0] sel);
    unique case (sel)
      2'h0: select_bucks = 2'h3;
      2'h1: select_bucks = 2'h1;
      2'h2: select_bucks = 2'h2;
      default: select_bucks = 2'h0;
    endcase
  endfunction

endpackage

// >>> hw/field_reg.sv
// one 24-bit register with per-bit reset classes
// assumes resets, load and write are all synchronous to clk_in
`timescale 1ns/1ns
module field_reg #(
  parameter int             W         = 24,
  parameter logic [W-1:0]   WMASK     = '1,
  parameter logic [W-1:0]   MAIN_MASK = '0,
  parameter logic [W-1:0]   OFF_MASK  = '0,
  parameter logic [W-1:0]   RST_VAL   = '0
) (
  input  wire logic         clk_in,
  input  wire logic         main_rst_in,
  input  wire logic         off_rst_in,
  input  wire logic         load_in,
  input  wire logic [W-1:0] load_mask_in,
  input  wire logic [W-1:0] load_val_in,
  input  wire logic         wr_in,
  input  wire logic [W-1:0] wdata_in,
  output logic      [W-1:0] q_out
);
  typedef struct packed { logic [W-1:0] bits; } state_s;
  state_s st_q;
  state_s st_d;

  // ==========================================================
  // resets beat load, load beats write; bits outside both masks keep state
  always_comb begin
    st_d = st_q;
    if (wr_in) begin
      st_d.bits = (st_q.bits & ~WMASK) | (wdata_in & WMASK);
    end
    if (load_in) begin
      st_d.bits = (st_d.bits & ~load_mask_in) | (load_val_in & load_mask_in);
    end
    if (off_rst_in) begin
      st_d.bits = (st_d.bits & ~OFF_MASK) | (RST_VAL & OFF_MASK);
    end
    if (main_rst_in) begin
      st_d.bits = (st_d.bits & ~MAIN_MASK) | (RST_VAL & MAIN_MASK);
    end
  end

  always_ff @(posedge clk_in) begin
    st_q <= st_d;
  end

  assign q_out = st_q.bits & WMASK;
endmodule // field_reg

// >>> hw/standby_gate.sv
// gates regulator enables with the standby input
// assumes standby_in is synchronous to the caller's clock
`timescale 1ns/1ns
module standby_gate #(
  parameter int            N = 15
) (
  input  wire logic [N-1:0] enable_in,
  input  wire logic [N-1:0] stby_ctl_in,
  input  wire logic         standby_in,
  output logic      [N-1:0] on_out
);
  // ==========================================================
  // off while standby asserted and the regulator follows standby
  assign on_out = enable_in & ~(stby_ctl_in & {N{standby_in}});
endmodule // standby_gate

// >>> hw/regulator_mode_register_bank.sv
// regulator mode register bank: buck modes, ldo settings and enables,
// general-purpose outputs and short-circuit protection enable
// assumes all inputs synchronous to clk_in; registers reached over a
// plain word port that the serial interface front end drives
`timescale 1ns/1ns

// What this block does
// - sequencer loads buck modes from power-up select
// - enabled buck starts in fixed PWM mode
// - buck three mode, hold, user-off in 29
// - buck four mode, hold, user-off in 29
// - general ldo one bits cleared by main reset
// - high io enable unreset, standby bit main-reset
// - digital ldo enable unreset, standby bit cleared
// - general ldo two enable unreset, others cleared
// - pll ldo enable unreset, standby bit cleared
// - second usb ldo enable, standby main-reset cleared
// - general ldo three bits 0-3 of 33
// - camera ldo bits 6-9 of 33 cleared
// - video ldo bits 12-14 of 33 cleared
// - audio ldo bits 15-16 of 33 cleared
// - sd card ldo bits 18-20 of 33
// - short protect enable bit 0, off after reset
// - four output enable/standby pairs, bits 6-13
module regulator_mode_register_bank
  import regbank_pkg::*;
#(
  parameter int                   P_NUM_LDO = NUM_LDO,
  parameter int                   P_NUM_GPO = NUM_GPO
) (
  input  wire logic               clk_in,
  input  wire logic               reset_in,
  input  wire logic               off_state_reset_in,
  input  wire logic               power_on_reset_in,
  input  wire logic [SEL_W-1:0]   power_up_mode_select_in,
  input  wire logic               standby_in,
  input  wire logic [ADDR_W-1:0]  reg_addr_in,
  input  wire logic               reg_wr_in,
  input  wire logic               reg_rd_in,
  input  wire logic [REG_W-1:0]   reg_wdata_in,
  output logic      [REG_W-1:0]   reg_rdata_out,
  output logic                    reg_rvalid_out,
  output logic                    startup_done_out,
  output logic      [3:0]         buck_three_mode_out,
  output logic                    buck_three_memory_hold_out,
  output logic                    buck_three_user_off_out,
  output logic      [3:0]         buck_four_mode_out,
  output logic                    buck_four_memory_hold_out,
  output logic                    buck_four_user_off_out,
  output logic                    boost_enable_out,
  output logic      [REG_W-1:0]   voltage_setting_a_out,
  output logic      [REG_W-1:0]   voltage_setting_b_out,
  output logic      [REG_W-1:0]   ldo_mode_control_a_out,
  output logic      [REG_W-1:0]   ldo_mode_control_b_out,
  output logic      [P_NUM_LDO-1:0] ldo_on_out,
  output logic      [P_NUM_GPO-1:0] general_output_on_out,
  output logic                    short_protect_enable_out
);

  // ==========================================================
  // state
  typedef enum logic [0:0] {SEQ_LOAD, SEQ_RUN} seq_e;

  typedef struct packed {
    seq_e                         seq;
    logic                         powered;
    logic [REG_W-1:0]             rdata;
    logic                         rvalid;
    logic [P_NUM_LDO-1:0]         ldo_on;
    logic [P_NUM_GPO-1:0]         gpo_on;
  } state_s;

  state_s st_q;
  state_s st_d;

  localparam int NG = P_NUM_LDO + P_NUM_GPO;

  word_t                regs      [NUM_REGS];
  logic [NUM_REGS-1:0]  wr_sel;
  logic [3:0]           dec;
  logic                 load_now;
  logic                 first_power;
  logic [1:0]           bucks_on;
  logic [3:0]           mode3;
  logic [3:0]           mode4;
  word_t                load_mask [NUM_REGS];
  word_t                load_val  [NUM_REGS];
  logic [NG-1:0]        gate_en;
  logic [NG-1:0]        gate_stby;
  logic [NG-1:0]        gate_on;

  // ==========================================================
  // register port decode
  assign dec = decode(reg_addr_in);

  always_comb begin
    for (int i = 0; i < NUM_REGS; i++) begin
      wr_sel[i] = reg_wr_in && dec[3] && (dec[2:0] == 3'(i));
    end
  end

  // ==========================================================
  // startup sequencer loads
  assign load_now    = (st_q.seq == SEQ_LOAD) && !reset_in;
  assign first_power = !st_q.powered;
  assign bucks_on    = select_bucks(power_up_mode_select_in);
  assign mode3       = bucks_on[0] ? MODE_PWM : MODE_OFF;
  assign mode4       = bucks_on[1] ? MODE_PWM : MODE_OFF;

  always_comb begin
    for (int i = 0; i < NUM_REGS; i++) begin
      // unreset bits get their values only on the first power-up
      load_mask[i] = first_power ?
                     (WRITE_MASK[i] & ~MAIN_MASK[i] & ~OFF_MASK[i]) : '0;
      load_val[i]  = POWERUP_VAL[i];
    end
    load_mask[IDX_BUCK][BUCK3_MODE_LSB +: BUCK_MODE_W] = 4'hf;
    load_mask[IDX_BUCK][BUCK4_MODE_LSB +: BUCK_MODE_W] = 4'hf;
    load_val[IDX_BUCK][BUCK3_MODE_LSB +: BUCK_MODE_W]  = mode3;
    load_val[IDX_BUCK][BUCK4_MODE_LSB +: BUCK_MODE_W]  = mode4;
  end

  // ==========================================================
  // register storage with per-bit reset classes
  for (genvar g = 0; g < NUM_REGS; g++) begin : g_reg
    field_reg #(
      .W         (REG_W),
      .WMASK     (WRITE_MASK[g]),
      .MAIN_MASK (MAIN_MASK[g]),
      .OFF_MASK  (OFF_MASK[g]),
      .RST_VAL   (RESET_VAL[g])
    ) u_reg (
      .clk_in       (clk_in),
      .main_rst_in  (reset_in),
      .off_rst_in   (off_state_reset_in),
      .load_in      (load_now),
      .load_mask_in (load_mask[g]),
      .load_val_in  (load_val[g]),
      .wr_in        (wr_sel[g]),
      .wdata_in     (reg_wdata_in),
      .q_out        (regs[g])
    );
  end

  // ==========================================================
  // standby gating of ldo and general output enables
  always_comb begin
    for (int i = 0; i < P_NUM_LDO; i++) begin
      gate_en[i]   = LDO_IN_B[i] ? regs[IDX_MODE_B][LDO_EN_BIT[i]]
                                 : regs[IDX_MODE_A][LDO_EN_BIT[i]];
      gate_stby[i] = LDO_IN_B[i] ? regs[IDX_MODE_B][LDO_STBY_BIT[i]]
                                 : regs[IDX_MODE_A][LDO_STBY_BIT[i]];
    end
    for (int k = 0; k < P_NUM_GPO; k++) begin
      gate_en[P_NUM_LDO+k]   = regs[IDX_MISC][GPO_EN_LSB + 2*k];
      gate_stby[P_NUM_LDO+k] = regs[IDX_MISC][GPO_EN_LSB + 2*k + 1];
    end
  end

  standby_gate #(
    .N (NG)
  ) u_gate (
    .enable_in   (gate_en),
    .stby_ctl_in (gate_stby),
    .standby_in  (standby_in),
    .on_out      (gate_on)
  );

  // ==========================================================
  // next state
  always_comb begin
    st_d        = st_q;
    st_d.rvalid = 1'b0;
    if (reg_rd_in) begin
      st_d.rdata  = dec[3] ? regs[dec[2:0]] : '0;
      st_d.rvalid = 1'b1;
    end
    st_d.ldo_on = gate_on[P_NUM_LDO-1:0];
    st_d.gpo_on = gate_on[NG-1:P_NUM_LDO];
    unique case (st_q.seq)
      SEQ_LOAD: begin
        st_d.seq     = SEQ_RUN;
        st_d.powered = 1'b1;
      end
      SEQ_RUN: begin
        st_d.seq = SEQ_RUN;
      end
    endcase
    if (reset_in) begin
      st_d.seq    = SEQ_LOAD;
      st_d.rdata  = '0;
      st_d.rvalid = 1'b0;
      st_d.ldo_on = '0;
      st_d.gpo_on = '0;
    end
    if (power_on_reset_in) begin
      st_d.powered = 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    st_q <= st_d;
  end

  // ==========================================================
  // outputs
  assign reg_rdata_out              = st_q.rdata;
  assign reg_rvalid_out             = st_q.rvalid;
  assign startup_done_out           = (st_q.seq == SEQ_RUN);
  assign buck_three_mode_out        = regs[IDX_BUCK][BUCK3_MODE_LSB +: BUCK_MODE_W];
  assign buck_three_memory_hold_out = regs[IDX_BUCK][BUCK3_HOLD_BIT];
  assign buck_three_user_off_out    = regs[IDX_BUCK][BUCK3_OFF_BIT];
  assign buck_four_mode_out         = regs[IDX_BUCK][BUCK4_MODE_LSB +: BUCK_MODE_W];
  assign buck_four_memory_hold_out  = regs[IDX_BUCK][BUCK4_HOLD_BIT];
  assign buck_four_user_off_out     = regs[IDX_BUCK][BUCK4_OFF_BIT];
  assign boost_enable_out           = regs[IDX_BUCK][BOOST_EN_BIT];
  assign voltage_setting_a_out      = regs[IDX_VSET_A];
  assign voltage_setting_b_out      = regs[IDX_VSET_B];
  assign ldo_mode_control_a_out     = regs[IDX_MODE_A];
  assign ldo_mode_control_b_out     = regs[IDX_MODE_B];
  assign ldo_on_out                 = st_q.ldo_on;
  assign general_output_on_out      = st_q.gpo_on;
  assign short_protect_enable_out   = regs[IDX_MISC][SHORT_PROT_BIT];

endmodule // regulator_mode_register_bank

// >>> verif/host_model.sv
// register port host: one write or read per call, driven at falling edges
// assumes the bank takes a strobe at the rising edge in the middle
`timescale 1ns/1ns
module host_model (
  input  wire logic        clk_in,
  output logic      [5:0]  addr_out,
  output logic             wr_out,
  output logic             rd_out,
  output logic      [23:0] wdata_out
);
  initial begin
    addr_out  = 6'h3f;
    wr_out    = 1'b0;
    rd_out    = 1'b0;
    wdata_out = 24'h0;
  end
  // released lines show inverted values so stale data is never trusted
  task automatic write(input logic [5:0] a, input logic [23:0] d);
    @(negedge clk_in);
    addr_out  = a;
    wdata_out = d;
    wr_out    = 1'b1;
    @(negedge clk_in);
    wr_out    = 1'b0;
    addr_out  = ~a;
    wdata_out = ~d;
  endtask
  task automatic read(input logic [5:0] a);
    @(negedge clk_in);
    addr_out = a;
    rd_out   = 1'b1;
    @(negedge clk_in);
    rd_out   = 1'b0;
    addr_out = ~a;
  endtask
endmodule // host_model

// >>> verif/regulator_mode_register_bank_assertions.sv
// port checker for the regulator mode register bank
// assumes one clock, synchronous active-high resets
`timescale 1ns/1ns
module regulator_mode_register_bank_assertions
  import regbank_pkg::*;
#(
  parameter int P_NUM_LDO = NUM_LDO
) (
  input wire logic                 clk_in,
  input wire logic                 reset_in,
  input wire logic                 off_state_reset_in,
  input wire logic [SEL_W-1:0]     power_up_mode_select_in,
  input wire logic                 standby_in,
  input wire logic [ADDR_W-1:0]    reg_addr_in,
  input wire logic                 reg_wr_in,
  input wire logic                 reg_rd_in,
  input wire logic [REG_W-1:0]     reg_wdata_in,
  input wire logic [REG_W-1:0]     reg_rdata_out,
  input wire logic                 reg_rvalid_out,
  input wire logic                 startup_done_out,
  input wire logic [3:0]           buck_three_mode_out,
  input wire logic                 buck_three_memory_hold_out,
  input wire logic                 buck_three_user_off_out,
  input wire logic [3:0]           buck_four_mode_out,
  input wire logic                 buck_four_memory_hold_out,
  input wire logic                 buck_four_user_off_out,
  input wire logic [REG_W-1:0]     voltage_setting_a_out,
  input wire logic [REG_W-1:0]     voltage_setting_b_out,
  input wire logic [REG_W-1:0]     ldo_mode_control_a_out,
  input wire logic [REG_W-1:0]     ldo_mode_control_b_out,
  input wire logic [P_NUM_LDO-1:0] ldo_on_out,
  input wire logic                 short_protect_enable_out
);
  // ==========================================================
  // expected gated enables, one cycle late
  logic [P_NUM_LDO-1:0] on_exp;
  logic [P_NUM_LDO-1:0] on_q;
  logic [REG_W-1:0]     w;
  logic [SEL_W-1:0]     sel_q;
  logic                 rst_q;
  always_comb begin
    w = '0;
    for (int i = 0; i < P_NUM_LDO; i++) begin
      w = LDO_IN_B[i] ? ldo_mode_control_b_out : ldo_mode_control_a_out;
      on_exp[i] = w[LDO_EN_BIT[i]] & ~(w[LDO_STBY_BIT[i]] & standby_in);
    end
  end
  always_ff @(posedge clk_in) begin
    rst_q  <= reset_in;
    on_q   <= on_exp;
    sel_q  <= power_up_mode_select_in;
  end
  // ==========================================================
  // assertions
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);
  a_read_valid: assert property (reg_rd_in |=> reg_rvalid_out)
    else $error("read not answered");
  a_reset_defaults: assert property ($fell(reset_in) |->
    !short_protect_enable_out && ldo_mode_control_b_out == '0 &&
    voltage_setting_b_out == 24'h0001d8 && buck_three_mode_out == 4'ha &&
    buck_four_mode_out == 4'ha)
    else $error("reset defaults wrong");
  a_startup_modes: assert property ($fell(reset_in) |=>
    buck_three_mode_out == (sel_q[1] ? 4'h0 : 4'ha) &&
    buck_four_mode_out == (sel_q[0] ? 4'h0 : 4'ha))
    else $error("startup buck modes wrong");
  a_startup_done: assert property ($fell(reset_in) |->
    !startup_done_out ##1 startup_done_out)
    else $error("startup load not finished");
  a_off_clears: assert property (off_state_reset_in |=>
    !buck_three_memory_hold_out && !buck_three_user_off_out &&
    !buck_four_memory_hold_out && !buck_four_user_off_out)
    else $error("off reset left hold bits");
  a_reserved_zero: assert property (
    (voltage_setting_a_out & ~24'h075ff3) == '0 &&
    (voltage_setting_b_out & ~24'h0001fc) == '0 &&
    (ldo_mode_control_a_out & ~24'h1ffe3f) == '0 &&
    (ldo_mode_control_b_out & ~24'h1ff3ef) == '0)
    else $error("reserved bit set");
  a_unmapped_zero: assert property (
    reg_rd_in && (reg_addr_in < 6'h1d || reg_addr_in > 6'h22) |=> reg_rdata_out == '0)
    else $error("unmapped read not zero");
  a_mode_b_write: assert property (
    reg_wr_in && reg_addr_in == 6'h21 |=>
    ldo_mode_control_b_out == ($past(reg_wdata_in) & 24'h1ff3ef))
    else $error("mode b write wrong");
  a_standby_gate: assert property (!rst_q |-> ldo_on_out == on_q)
    else $error("gated enables wrong");
  c_standby: cover property (standby_in && ldo_on_out != on_exp);
  c_off_reset: cover property (off_state_reset_in && !reset_in);
  c_unmapped: cover property (reg_rd_in && reg_addr_in == 6'h23);
endmodule // regulator_mode_register_bank_assertions

bind regulator_mode_register_bank regulator_mode_register_bank_assertions #(
  .P_NUM_LDO(P_NUM_LDO)) i_chk (.clk_in(clk_in), .reset_in(reset_in),
  .off_state_reset_in(off_state_reset_in), .power_up_mode_select_in(power_up_mode_select_in),
  .standby_in(standby_in), .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in),
  .reg_rd_in(reg_rd_in), .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
  .reg_rvalid_out(reg_rvalid_out), .buck_three_mode_out(buck_three_mode_out),
  .buck_three_memory_hold_out(buck_three_memory_hold_out),
  .buck_three_user_off_out(buck_three_user_off_out), .buck_four_mode_out(buck_four_mode_out),
  .buck_four_memory_hold_out(buck_four_memory_hold_out),
  .buck_four_user_off_out(buck_four_user_off_out), .voltage_setting_b_out(voltage_setting_b_out),
  .ldo_mode_control_a_out(ldo_mode_control_a_out),
  .startup_done_out(startup_done_out), .voltage_setting_a_out(voltage_setting_a_out),
  .ldo_mode_control_b_out(ldo_mode_control_b_out), .ldo_on_out(ldo_on_out),
  .short_protect_enable_out(short_protect_enable_out));

// >>> verif/regulator_mode_register_bank_tb.sv
// self-checking bench for the regulator mode register bank
// assumes host_model drives the register port; reads scored by queue
`timescale 1ns/1ns
module regulator_mode_register_bank_tb
  import regbank_pkg::*;
;
  logic               clk_in = 1'b0;
  logic               reset_in, off_rst, por_rst, standby, wr, rd, rvalid, short_prot;
  logic [1:0]         mode_sel;
  logic [5:0]         addr;
  logic [23:0]        wdata, rdata, d;
  logic [NUM_LDO-1:0] ldo_on;
  logic [NUM_GPO-1:0] gpo_on;
  int                 err_count = 0;
  int                 checks = 0;
  int                 cycles = 0;
  int                 seed;
  logic [23:0]        expq [$];
  // writable, first power-up and after-main-reset images per register
  logic [23:0] wm [6] = '{24'h103f3f, 24'h075ff3, 24'h0001fc, 24'h1ffe3f, 24'h1ff3ef, 24'h003fc1};
  logic [23:0] rv [6] = '{24'h0, 24'h024000, 24'h0001d8, 24'h009208, 24'h0, 24'h0};
  logic [23:0] mr [6] = '{24'h103030, 24'h025ff0, 24'h0001d8, 24'h009208, 24'h0, 24'h0};

  regulator_mode_register_bank i_dut (.clk_in(clk_in), .reset_in(reset_in),
    .off_state_reset_in(off_rst), .power_on_reset_in(por_rst),
    .power_up_mode_select_in(mode_sel), .standby_in(standby), .reg_addr_in(addr),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
    .reg_rvalid_out(rvalid), .startup_done_out(), .buck_three_mode_out(),
    .buck_three_memory_hold_out(), .buck_three_user_off_out(), .buck_four_mode_out(),
    .buck_four_memory_hold_out(), .buck_four_user_off_out(), .boost_enable_out(),
    .voltage_setting_a_out(), .voltage_setting_b_out(), .ldo_mode_control_a_out(),
    .ldo_mode_control_b_out(), .ldo_on_out(ldo_on), .general_output_on_out(gpo_on),
    .short_protect_enable_out(short_prot));
  host_model i_host (.clk_in(clk_in), .addr_out(addr), .wr_out(wr), .rd_out(rd),
    .wdata_out(wdata));

  initial begin
    forever #10 clk_in = ~clk_in;
  end
  // ==========================================================
  // checking and closing
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    if (err_count == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  always @(negedge clk_in) begin
    if (rvalid === 1'b1) begin
      if (expq.size() > 0) begin
        check(rdata, expq.pop_front());
      end else begin
        check(24'(expq.size()), 24'h1);
      end
    end
  end
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      summarize();
    end
  end
  // ==========================================================
  // stimulus helpers
  task automatic rd_exp(input logic [5:0] a, input logic [23:0] e);
    expq.push_back(e);
    i_host.read(a);
  endtask
  task automatic pulse(input logic [2:0] which);
    @(negedge clk_in);
    {reset_in, off_rst, por_rst} = which;
    repeat (4) @(negedge clk_in);
    {reset_in, off_rst, por_rst} = 3'b000;
    repeat (2) @(negedge clk_in);
  endtask
  // buck mode image chosen by the power-up select, boost on
  function automatic logic [23:0] bm();
    bm = {12'h100, mode_sel[0] ? 4'h0 : 4'ha, 4'h0, mode_sel[1] ? 4'h0 : 4'ha};
  endfunction
  // ==========================================================
  // main sequence
  initial begin
    {reset_in, off_rst, por_rst} = 3'b111;
    standby = 1'b0;
    mode_sel = 2'h0;
    seed = $urandom(34);
    for (int p = 0; p < 4; p++) begin
      mode_sel = 2'(p);
      pulse(3'b111);
      rd_exp(6'h1d, bm());
      for (int i = 1; i < 6; i++) rd_exp(6'h1d + 6'(i), rv[i]);
    end
    for (int i = 0; i < 6; i++) begin
      d = 24'($urandom);
      i_host.write(6'h1d + 6'(i), d);
      rd_exp(6'h1d + 6'(i), d & wm[i]);
    end
    i_host.write(6'h23, 24'hffffff);
    rd_exp(6'h1c, 24'h0);
    rd_exp(6'h23, 24'h0);
    for (int i = 0; i < 6; i++) i_host.write(6'h1d + 6'(i), 24'hffffff);
    check({23'h0, short_prot}, 24'h1);
    pulse(3'b100);
    check({20'h0, gpo_on}, 24'h0);
    rd_exp(6'h1d, mr[0] | bm());
    for (int i = 1; i < 6; i++) begin
      rd_exp(6'h1d + 6'(i), mr[i]);
    end
    pulse(3'b010);
    rd_exp(6'h1d, bm());
    i_host.write(6'h20, 24'h00000b);
    i_host.write(6'h22, 24'h0001c0);
    standby = 1'b1;
    repeat (2) @(negedge clk_in);
    check({13'h0, ldo_on}, 24'h2);
    check({20'h0, gpo_on}, 24'h2);
    standby = 1'b0;
    repeat (2) @(negedge clk_in);
    check({13'h0, ldo_on}, 24'h3);
    check({20'h0, gpo_on}, 24'h3);
    repeat (3) @(negedge clk_in);
    check(24'(expq.size()), 24'h0);
    summarize();
  end
endmodule // regulator_mode_register_bank_tb
